// [sofm_pkg.sv]
// constants and types shared by the safety output feedback monitor
package sofm_pkg;
	// system clock rate and the millisecond timebase derived from it
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned MS_PER_SEC    = 1000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_SEC;
	localparam int unsigned MS_CNT_W      = 14;
	// feedback window in milliseconds, default and counter width
	localparam int unsigned FBK_WIN_W     = 10;
	localparam logic [9:0]  FBK_WIN_RST   = 10'h064;
	// monitor field sizes, larger and smaller master
	localparam int unsigned PROBE_BIG     = 32;
	localparam int unsigned PROBE_SMALL   = 16;
	localparam int unsigned PROBE_BYTES_BIG   = 4;
	localparam int unsigned PROBE_BYTES_SMALL = 2;
	localparam int unsigned PROBE_SEL_W   = 6;
	// single-channel group and relay channel count
	localparam int unsigned SGL_CH        = 4;
	localparam int unsigned RLY_CH        = 4;
	// relay category codes
	localparam logic [1:0]  CAT_LOW       = 2'h0;
	localparam logic [1:0]  CAT_MID       = 2'h1;
	localparam logic [1:0]  CAT_HIGH      = 2'h2;
	// lamp flash half period in milliseconds
	localparam logic [8:0]  FLASH_HALF_MS = 9'h0FA;

	// restart sequencer states, gray along the usual path
	typedef enum logic [1:0] {
		SOFM_IDLE  = 2'b00,
		SOFM_ARMED = 2'b01,
		SOFM_HIGH  = 2'b11,
		SOFM_RUN   = 2'b10
	} sofm_rst_t;
endpackage : sofm_pkg

// [sofm_sync.sv]
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module sofm_sync
	import sofm_pkg::*;
#(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// raw and settled level
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] clean
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] clean_r;

	// first stage feeds only the second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			clean_r <= '0;
		end else begin
			s1_r    <= raw;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			clean_r <= (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
		end
	end

	assign clean = clean_r;
endmodule : sofm_sync

// [sofm_chan.sv]
// one output channel: restart handling and contactor feedback window
`timescale 1ns/100ps
module sofm_chan
	import sofm_pkg::*;
(
	// clock, reset, timebase
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic                 ms_tick,
	// configuration
	input  wire logic                 restart_en,
	input  wire logic                 restart_monitored,
	input  wire logic                 fbk_check_en,
	input  wire logic [FBK_WIN_W-1:0] fbk_window_ms,
	// live signals
	input  wire logic                 logic_in,
	input  wire logic                 restart_in,
	input  wire logic                 fbk_in,
	input  wire logic                 fault_clear,
	// results
	output logic                      out_on,
	output logic                      fault
);
	sofm_rst_t            st_r;
	sofm_rst_t            st_nxt;
	logic                 rst_d_r;
	logic                 out_r;
	logic                 fault_r;
	logic [FBK_WIN_W-1:0] win_r;
	logic                 pend_r;

	wire rise      = restart_in & ~rst_d_r;
	wire fall      = ~restart_in & rst_d_r;
	wire want_on   = logic_in & ~fault_r & (!restart_en || st_r == SOFM_RUN);  // R01 R02
	wire fbk_ok    = (fbk_in == ~out_r);                                       // R06
	wire win_over  = pend_r && ms_tick && (win_r >= fbk_window_ms);
	wire fbk_fail  = fbk_check_en && win_over && !fbk_ok;                      // R07

	// restart sequencer; a falling logic input always demands a new restart
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			SOFM_IDLE:  if (logic_in) st_nxt = SOFM_ARMED;
			SOFM_ARMED: begin
				if (!logic_in) st_nxt = SOFM_IDLE;
				else if (rise && !restart_monitored) st_nxt = SOFM_RUN;  // R03
				else if (rise) st_nxt = SOFM_HIGH;
			end
			SOFM_HIGH: begin
				if (!logic_in) st_nxt = SOFM_IDLE;
				else if (fall) st_nxt = SOFM_RUN;                        // R04
			end
			SOFM_RUN:   if (!logic_in) st_nxt = SOFM_IDLE;             // R02
		endcase
	end

	// window counter restarts on every output change
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_r    <= SOFM_IDLE;
			rst_d_r <= 1'b0;
			out_r   <= 1'b0;
			fault_r <= 1'b0;
			win_r   <= '0;
			pend_r  <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			rst_d_r <= restart_in;
			out_r   <= want_on && !fbk_fail;
			if (fbk_fail)
				fault_r <= 1'b1;                       // R08 R09
			else if (fault_clear)
				fault_r <= 1'b0;                       // R09
			if (out_r != (want_on && !fbk_fail)) begin
				win_r  <= '0;                          // R20
				pend_r <= 1'b1;
			end else if (win_over || (pend_r && fbk_ok)) begin
				pend_r <= 1'b0;
			end else if (pend_r && ms_tick) begin
				win_r  <= win_r + 1'b1;                // R20
			end
		end
	end

	assign out_on = out_r;
	assign fault  = fault_r;

	chk_latch_hold: assert property (@(posedge mclk) disable iff (!rstn)  // R09
		fault_r && !fault_clear |=> fault_r)
		else $error("fault flag dropped without clear");
	chk_fault_off: assert property (@(posedge mclk) disable iff (!rstn)  // R07
		fault_r |-> ##1 !out_r)
		else $error("output on while faulted");
endmodule : sofm_chan

// [sofm_top.sv]
// safety output feedback monitor: paired, single, status, probe and relay outputs
// What this block does
// R01 - paired output drives both channels on while input is 1, off while 0
// R02 - restart option demands a new restart after each input fall
// R03 - plain restart accepts a single 0 to 1 edge of restart input
// R04 - monitored restart needs 0 to 1 then back to 0
// R05 - status option mirrors the present safety output state
// R06 - feedback must become inverse of output within the window
// R07 - missed feedback forces the output low and flashes its lamp
// R08 - error flag goes high on an external feedback fault
// R09 - error flag latches until power cycle or global fault clear
// R10 - single-channel output on while input 1, off while 0
// R11 - single blocks configure as single or double type, paired in groups
// R12 - restart/feedback input present only when used, or always on some variants
// R13 - status output mirrors its input with no checking
// R14 - up to 32 or 16 monitor points, each mapped to a bit
// R15 - monitor field is 4 bytes or 2 bytes by master size
// R16 - relay contact closes while input is 1
// R17 - three categories; lowest has internal monitoring, no contactor check
// R18 - middle category always checks feedback, only with automatic restart
// R19 - middle category fault report stays on, drops on any feedback fault
// R20 - feedback window counted in milliseconds, restarts at every output change
`timescale 1ns/100ps
module sofm_top
	import sofm_pkg::*;
#(
	parameter int unsigned NPROBE      = PROBE_BIG,
	parameter int unsigned SIG_W       = 64,
	parameter bit          ALWAYS_RFBK = 1'b0
) (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rstn,
	// global controls
	input  wire logic                        global_fault_clear,
	input  wire logic                        large_master,
	// paired safe switching output configuration and signals
	input  wire logic                        pair_in,
	input  wire logic                        pair_restart_en,
	input  wire logic                        pair_restart_mon,
	input  wire logic                        pair_status_en,
	input  wire logic                        pair_fbk_en,
	input  wire logic                        pair_err_en,
	input  wire logic [FBK_WIN_W-1:0]        pair_window_ms,
	input  wire logic                        pair_restart_feedback_input,
	output logic [1:0]                       pair_safe_switching_output,
	output logic                             pair_status,
	output logic                             pair_error,
	output logic                             pair_channel_fault_lamp,
	// single-channel group
	input  wire logic [SGL_CH-1:0]           sgl_in,
	input  wire logic [SGL_CH/2-1:0]         sgl_double,
	input  wire logic                        sgl_restart_en,
	input  wire logic                        sgl_restart_mon,
	input  wire logic                        sgl_fbk_en,
	input  wire logic [FBK_WIN_W-1:0]        sgl_window_ms,
	input  wire logic [SGL_CH-1:0]           sgl_restart_feedback_input,
	output logic [SGL_CH-1:0]                sgl_safe_switching_output,
	output logic [SGL_CH-1:0]                sgl_error,
	output logic [SGL_CH-1:0]                sgl_channel_fault_lamp,
	output logic [SGL_CH-1:0]                sgl_rfbk_present,
	// status outputs
	input  wire logic [SGL_CH-1:0]           stat_in,
	output logic [SGL_CH-1:0]                stat_out,
	// fieldbus monitor points
	input  wire logic [SIG_W-1:0]            diag_sig,
	input  wire logic [NPROBE*PROBE_SEL_W-1:0] probe_sel,
	input  wire logic [NPROBE-1:0]           probe_en,
	output logic [8*PROBE_BYTES_BIG-1:0]     probe_field,
	// relays
	input  wire logic [RLY_CH-1:0]           rly_in,
	input  wire logic [1:0]                  rly_category,
	input  wire logic                        rly_restart_en,
	input  wire logic [FBK_WIN_W-1:0]        rly_window_ms,
	input  wire logic [RLY_CH-1:0]           rly_contactor_feedback,
	input  wire logic [RLY_CH-1:0]           rly_internal_ok,
	output logic [RLY_CH-1:0]                rly_contact,
	output logic [RLY_CH-1:0]                rly_fault_report_output
);
	localparam int unsigned NCH = 1 + SGL_CH + RLY_CH;

	logic [MS_CNT_W-1:0] ms_cnt_r;
	logic                ms_tick_r;
	logic [8:0]          flash_cnt_r;
	logic                flash_r;
	// wrap after exactly the half period; the counter starts at zero
	wire                 flash_wrap = (flash_cnt_r == FLASH_HALF_MS - 9'h001);

	// pin inputs settle through three stages
	logic [NCH-1:0] fbk_s;
	logic [NCH-1:0] rfbk_raw;
	logic           clr_s;
	assign rfbk_raw = {rly_contactor_feedback, sgl_restart_feedback_input,
		pair_restart_feedback_input};

	sofm_sync #(.W(NCH)) u_sync_fbk (
		.mclk  (mclk),
		.rstn  (rstn),
		.raw   (rfbk_raw),
		.clean (fbk_s)
	);
	sofm_sync #(.W(1)) u_sync_clr (
		.mclk  (mclk),
		.rstn  (rstn),
		.raw   (global_fault_clear),
		.clean (clr_s)
	);

	// millisecond timebase and lamp flash; one clock, enables only
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ms_cnt_r    <= '0;
			ms_tick_r   <= 1'b0;
			flash_cnt_r <= '0;
			flash_r     <= 1'b1;  // lamp flash starts in its lit half after reset
		end else begin
			ms_tick_r <= (ms_cnt_r == MS_CNT_W'(CYC_PER_MS - 1));     // R20
			ms_cnt_r  <= (ms_cnt_r == MS_CNT_W'(CYC_PER_MS - 1)) ? '0 : ms_cnt_r + 1'b1;
			if (ms_tick_r) begin
				flash_cnt_r <= flash_wrap ? '0 : flash_cnt_r + 1'b1;
				if (flash_wrap)
					flash_r <= ~flash_r;
			end
		end
	end

	// per-channel configuration; the pair's restart input doubles as feedback,
	// so both share one pin and the feedback check is enabled only when restart is off
	logic [NCH-1:0]   ch_in;
	logic [NCH-1:0]   ch_rst_en;
	logic [NCH-1:0]   ch_rst_mon;
	logic [NCH-1:0]   ch_fbk_en;
	logic [NCH-1:0]   ch_on;
	logic [NCH-1:0]   ch_fault;
	logic [FBK_WIN_W-1:0] ch_win [NCH];

	wire cat_mid = (rly_category == CAT_MID);
	wire cat_low = (rly_category == CAT_LOW);
	// middle category forces feedback check and forbids restart request
	wire rly_rst = rly_restart_en && !cat_mid;                        // R18
	wire rly_fbk = !cat_low;                                          // R17 R18

	// double type ties each pair of single channels to the lower input
	logic [SGL_CH-1:0] sgl_eff_in;
	genvar g;
	generate
		for (g = 0; g < SGL_CH; g++) begin : g_sgl_in
			assign sgl_eff_in[g] = sgl_double[g/2] ? sgl_in[g & ~1] : sgl_in[g];  // R11
		end
	endgenerate

	assign ch_in      = {rly_in, sgl_eff_in, pair_in};
	assign ch_rst_en  = {{RLY_CH{rly_rst}}, {SGL_CH{sgl_restart_en}}, pair_restart_en};
	assign ch_rst_mon = {{RLY_CH{1'b0}}, {SGL_CH{sgl_restart_mon}}, pair_restart_mon};
	assign ch_fbk_en  = {{RLY_CH{rly_fbk}}, {SGL_CH{sgl_fbk_en}}, pair_fbk_en};

	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			assign ch_win[g] = (g == 0) ? pair_window_ms :
				(g <= SGL_CH) ? sgl_window_ms : rly_window_ms;
			sofm_chan u_chan (
				.mclk              (mclk),
				.rstn              (rstn),
				.ms_tick           (ms_tick_r),
				.restart_en        (ch_rst_en[g]),
				.restart_monitored (ch_rst_mon[g]),
				.fbk_check_en      (ch_fbk_en[g] && !ch_rst_en[g]),
				.fbk_window_ms     (ch_win[g]),
				.logic_in          (ch_in[g]),
				.restart_in        (fbk_s[g]),
				.fbk_in            (fbk_s[g]),
				.fault_clear       (clr_s),
				.out_on            (ch_on[g]),
				.fault             (ch_fault[g])
			);
		end
	endgenerate

	// probe selection: each point picks one diagram signal for its bit
	function automatic logic pick(input logic [SIG_W-1:0] s, input logic [PROBE_SEL_W-1:0] i);
		pick = s[i];
	endfunction

	logic [8*PROBE_BYTES_BIG-1:0] probe_nxt;
	generate
		for (g = 0; g < 8*PROBE_BYTES_BIG; g++) begin : g_probe
			if (g < NPROBE) begin : g_live
				assign probe_nxt[g] = probe_en[g] && pick(diag_sig,   // R14
					probe_sel[g*PROBE_SEL_W +: PROBE_SEL_W]) &&
					(large_master || g < PROBE_SMALL);                  // R15
			end else begin : g_none
				assign probe_nxt[g] = 1'b0;
			end
		end
	endgenerate

	// registered outputs
	logic [1:0]        pair_oss_r;
	logic              pair_stat_r;
	logic              pair_err_r;
	logic              pair_lamp_r;
	logic [SGL_CH-1:0] sgl_out_r;
	logic [SGL_CH-1:0] sgl_err_r;
	logic [SGL_CH-1:0] sgl_lamp_r;
	logic [SGL_CH-1:0] sgl_pres_r;
	logic [SGL_CH-1:0] stat_r;
	logic [8*PROBE_BYTES_BIG-1:0] probe_r;
	logic [RLY_CH-1:0] rly_r;
	logic [RLY_CH-1:0] rpt_r;

	wire [SGL_CH-1:0] sgl_on    = ch_on[SGL_CH:1];
	wire [SGL_CH-1:0] sgl_flt   = ch_fault[SGL_CH:1];
	wire [RLY_CH-1:0] rly_on    = ch_on[NCH-1:SGL_CH+1];
	wire [RLY_CH-1:0] rly_flt   = ch_fault[NCH-1:SGL_CH+1];
	wire              sgl_pres  = ALWAYS_RFBK || sgl_restart_en || sgl_fbk_en;  // R12

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pair_oss_r  <= 2'h0;
			pair_stat_r <= 1'b0;
			pair_err_r  <= 1'b0;
			pair_lamp_r <= 1'b0;
			sgl_out_r   <= '0;
			sgl_err_r   <= '0;
			sgl_lamp_r  <= '0;
			sgl_pres_r  <= '0;
			stat_r      <= '0;
			probe_r     <= '0;
			rly_r       <= '0;
			rpt_r       <= '0;
		end else begin
			pair_oss_r  <= {2{ch_on[0]}};                             // R01
			pair_stat_r <= pair_status_en && ch_on[0];                // R05
			pair_err_r  <= pair_err_en && ch_fault[0];                // R08
			pair_lamp_r <= ch_fault[0] && flash_r;                    // R07
			sgl_out_r   <= sgl_on;                                    // R10
			sgl_err_r   <= sgl_flt;                                   // R08
			sgl_lamp_r  <= sgl_flt & {SGL_CH{flash_r}};               // R07
			sgl_pres_r  <= {SGL_CH{sgl_pres}};                        // R12
			stat_r      <= stat_in;                                   // R13
			probe_r     <= probe_nxt;                                 // R14 R15
			rly_r       <= rly_on & rly_internal_ok;                  // R16 R17
			rpt_r       <= cat_mid ? ~(rly_flt | ~rly_internal_ok) : '0;  // R19
		end
	end

	assign pair_safe_switching_output = pair_oss_r;
	assign pair_status                = pair_stat_r;
	assign pair_error                 = pair_err_r;
	assign pair_channel_fault_lamp    = pair_lamp_r;
	assign sgl_safe_switching_output  = sgl_out_r;
	assign sgl_error                  = sgl_err_r;
	assign sgl_channel_fault_lamp     = sgl_lamp_r;
	assign sgl_rfbk_present           = sgl_pres_r;
	assign stat_out                   = stat_r;
	assign probe_field                = probe_r;
	assign rly_contact                = rly_r;
	assign rly_fault_report_output    = rpt_r;

	// checks on registered outputs; latch and forced-off checks sit in the channel
	chk_pair_follow: assert property (@(posedge mclk) disable iff (!rstn)  // R01
		!pair_in |-> ##[1:8] !pair_safe_switching_output[0])
		else $error("pair output stayed on after input low");
	chk_status_mirror: assert property (@(posedge mclk) disable iff (!rstn)  // R13
		1'b1 |=> stat_out == $past(stat_in))
		else $error("status output not mirroring");
	chk_small_field: assert property (@(posedge mclk) disable iff (!rstn)  // R15
		!$past(large_master) |-> probe_field[31:16] == 16'h0000)
		else $error("upper probe bytes set on small master");
	chk_relay_open: assert property (@(posedge mclk) disable iff (!rstn)  // R16
		rly_contact[0] |-> $past(ch_on[SGL_CH+1]))
		else $error("relay closed without input");
	chk_ote_drop: assert property (@(posedge mclk) disable iff (!rstn)  // R19
		cat_mid && rly_flt[0] |=> !rly_fault_report_output[0])
		else $error("fault report stayed on during fault");
	chk_err_gate: assert property (@(posedge mclk) disable iff (!rstn)  // R08
		pair_error |-> $past(pair_err_en))
		else $error("error flag without enable");
	chk_lamp_dark: assert property (@(posedge mclk) disable iff (!rstn)  // R07
		!ch_fault[0] |=> !pair_channel_fault_lamp)
		else $error("lamp lit without a fault");
	chk_sgl_lamp: assert property (@(posedge mclk) disable iff (!rstn)  // R07
		(sgl_channel_fault_lamp & ~$past(sgl_flt)) == 4'h0)
		else $error("single lamp lit without a fault");
	chk_status_state: assert property (@(posedge mclk) disable iff (!rstn)  // R05
		pair_status |-> pair_safe_switching_output == 2'b11)
		else $error("status shows on while output is off");
	chk_rpt_low: assert property (@(posedge mclk) disable iff (!rstn)  // R19
		!$past(cat_mid) |-> rly_fault_report_output == 4'h0)
		else $error("fault report on outside middle category");
	// main scenarios a run should reach
	cov_pair_on: cover property (@(posedge mclk) disable iff (!rstn)
		$rose(pair_safe_switching_output[0]));
	cov_pair_fault: cover property (@(posedge mclk) disable iff (!rstn)
		$rose(pair_error));
	cov_relay_ote: cover property (@(posedge mclk) disable iff (!rstn)
		$fell(rly_fault_report_output[0]));
	cov_sgl_double: cover property (@(posedge mclk) disable iff (!rstn)
		sgl_double[0] && sgl_safe_switching_output[1:0] == 2'b11);
	cov_probe_small: cover property (@(posedge mclk) disable iff (!rstn)
		!large_master && probe_field[15:0] != 16'h0000);
endmodule : sofm_top

// [sofm_contactor.sv]
// behavioural external contactor whose feedback contact opens when the coil is driven
`timescale 1ns/100ps
module sofm_contactor #(
	parameter int unsigned W   = 1,
	parameter int unsigned DLY = 20
) (
	// clock
	input  wire logic         mclk,
	// coil drive and fault injection
	input  wire logic [W-1:0] coil,
	input  wire logic         stuck,
	// feedback contact level
	output logic      [W-1:0] contactor_feedback
);
	logic [DLY-1:0][W-1:0] pipe_r = '0;
	logic [W-1:0]          fbk_r  = '1;

	// mechanical lag before the feedback contact follows the coil
	always_ff @(posedge mclk) begin
		pipe_r <= {pipe_r[DLY-2:0], coil};
	end

	// feedback is the inverse of the coil; a welded contact freezes it
	always_ff @(posedge mclk) begin
		fbk_r <= stuck ? fbk_r : ~pipe_r[DLY-1];
	end

	assign contactor_feedback = fbk_r;
endmodule : sofm_contactor

// [sofm_top_test.sv]
// self-checking testbench of the safety output feedback monitor
`timescale 1ns/100ps
module sofm_top_test;
	import sofm_pkg::*;
	localparam int unsigned NP = PROBE_BIG;
	// design inputs
	logic mclk = 1'b0, rstn = 1'b0, global_fault_clear = 1'b0, large_master = 1'b1;
	logic pair_in, pair_restart_en, pair_restart_mon, pair_status_en, pair_fbk_en, pair_err_en;
	logic [FBK_WIN_W-1:0] pair_window_ms, sgl_window_ms, rly_window_ms;
	logic [SGL_CH-1:0] sgl_in, sgl_restart_feedback_input, stat_in;
	logic [1:0] sgl_double, rly_category;
	logic sgl_restart_en, sgl_restart_mon, sgl_fbk_en, rly_restart_en;
	logic [63:0] diag_sig;
	logic [NP*PROBE_SEL_W-1:0] probe_sel;
	logic [NP-1:0] probe_en;
	logic [RLY_CH-1:0] rly_in, rly_internal_ok, rly_contactor_feedback;
	// design outputs
	logic [1:0] pair_safe_switching_output;
	logic pair_status, pair_error, pair_channel_fault_lamp;
	logic [SGL_CH-1:0] sgl_safe_switching_output, sgl_error, sgl_channel_fault_lamp;
	logic [SGL_CH-1:0] sgl_rfbk_present, stat_out;
	logic [31:0] probe_field;
	logic [RLY_CH-1:0] rly_contact, rly_fault_report_output;
	// shared restart/feedback pin of the paired output
	logic tb_rst_pin = 1'b0, use_fb = 1'b0, stuck = 1'b0;
	logic pfb;
	wire logic pair_restart_feedback_input = use_fb ? pfb : tb_rst_pin;
	int fail_count = 0;
	int total_checks = 0;
	logic [31:0] exp_f;

	always #50 mclk = ~mclk;

	sofm_top #(.NPROBE(NP)) DUT (.*);

	// contactors on the paired output and on the relays
	sofm_contactor #(.W(1)) pair_k (.mclk(mclk), .coil(pair_safe_switching_output[0]),
		.stuck(stuck), .contactor_feedback(pfb));
	sofm_contactor #(.W(RLY_CH)) rly_k (.mclk(mclk), .coil(rly_contact), .stuck(stuck),
		.contactor_feedback(rly_contactor_feedback));

	// inputs change a fixed 10 ns after the rising edge
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#10;
	endtask : cyc

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// bounded wait for the paired output; a lapse ends the run
	task automatic wait_pair(input logic [1:0] exp, input int lim);
		int i;
		for (i = 0; i < lim && pair_safe_switching_output !== exp; i++)
			cyc(1);
		if (i == lim) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, pair_safe_switching_output, exp);
			conclude();
		end else begin
			chk(pair_safe_switching_output, exp);
		end
	endtask : wait_pair

	initial begin
		{pair_in, pair_restart_en, pair_restart_mon, pair_status_en} = '0;
		{pair_fbk_en, pair_err_en, sgl_restart_en, sgl_restart_mon, sgl_fbk_en} = '0;
		{sgl_in, sgl_restart_feedback_input, stat_in, sgl_double} = '0;
		{rly_in, rly_category, rly_restart_en, diag_sig, probe_sel, probe_en} = '0;
		pair_window_ms = 10'h002;
		sgl_window_ms = 10'h002;
		rly_window_ms = 10'h001;
		rly_internal_ok = 4'hf;
		cyc(2);
		rstn = 1'b1;
		cyc(6);
		// direct following and status mirror
		pair_status_en = 1'b1;
		pair_in = 1'b1;
		wait_pair(2'b11, 20);
		cyc(2);
		chk(pair_status, 1'b1);
		pair_in = 1'b0;
		wait_pair(2'b00, 20);
		$display("test direct done");
		// plain restart: one rising edge, demanded again after each fall
		pair_restart_en = 1'b1;
		repeat (2) begin
			pair_in = 1'b1;
			cyc(30);
			chk(pair_safe_switching_output, 2'b00);
			tb_rst_pin = 1'b1;
			wait_pair(2'b11, 20);
			tb_rst_pin = 1'b0;
			pair_in = 1'b0;
			wait_pair(2'b00, 20);
		end
		$display("test plain restart done");
		// monitored restart waits for the falling half of the pulse
		pair_restart_mon = 1'b1;
		pair_in = 1'b1;
		cyc(5);
		tb_rst_pin = 1'b1;
		cyc(30);
		chk(pair_safe_switching_output, 2'b00);
		tb_rst_pin = 1'b0;
		wait_pair(2'b11, 20);
		pair_in = 1'b0;
		wait_pair(2'b00, 20);
		{pair_restart_en, pair_restart_mon} = 2'b00;
		$display("test monitored restart done");
		// contactor answers in time: output holds past the window
		use_fb = 1'b1;
		pair_fbk_en = 1'b1;
		pair_err_en = 1'b1;
		cyc(10);
		pair_in = 1'b1;
		wait_pair(2'b11, 20);
		cyc(32000);
		chk({pair_safe_switching_output, pair_error}, 3'b110);
		chk(pair_channel_fault_lamp, 1'b0);
		pair_in = 1'b0;
		wait_pair(2'b00, 20);
		cyc(30);
		// welded contactor: output forced off and the flag latches
		stuck = 1'b1;
		pair_in = 1'b1;
		wait_pair(2'b11, 20);
		cyc(19000);
		chk(pair_safe_switching_output, 2'b11);
		wait_pair(2'b00, 13000);
		cyc(2);
		chk(pair_error, 1'b1);
		chk(pair_channel_fault_lamp, 1'b1);
		stuck = 1'b0;
		pair_in = 1'b0;
		cyc(200);
		chk(pair_error, 1'b1);
		global_fault_clear = 1'b1;
		cyc(10);
		global_fault_clear = 1'b0;
		cyc(10);
		chk(pair_error, 1'b0);
		chk(pair_channel_fault_lamp, 1'b0);
		{use_fb, pair_fbk_en} = 2'b00;
		$display("test feedback done");
		// single channels, double pairing and the restart input presence
		sgl_in = 4'b0101;
		cyc(8);
		chk(sgl_safe_switching_output, 4'b0101);
		chk(sgl_rfbk_present, 4'b0000);
		chk({sgl_error, sgl_channel_fault_lamp}, 8'h00);
		sgl_double = 2'b01;
		sgl_in = 4'b1001;
		cyc(8);
		chk(sgl_safe_switching_output, 4'b1011);
		sgl_restart_en = 1'b1;
		cyc(4);
		chk(sgl_rfbk_present, 4'b1111);
		// status mirror
		stat_in = 4'b1010;
		cyc(2);
		chk(stat_out, 4'b1010);
		$display("test single and status done");
		// probe point i shows diagram signal 63-2i on bit i; point 5 unused
		diag_sig = 64'h3c5a_96f0_0ff1_a5c3;
		probe_en = 32'hffff_ffdf;
		for (int i = 0; i < NP; i++) begin
			probe_sel[i*PROBE_SEL_W +: PROBE_SEL_W] = 6'(63 - 2 * i);
			exp_f[i] = probe_en[i] & diag_sig[63 - 2 * i];
		end
		cyc(3);
		chk(probe_field, exp_f);
		large_master = 1'b0;
		cyc(3);
		chk(probe_field, exp_f & 32'h0000_ffff);
		$display("test probe done");
		// relays: lowest category, then middle which ignores the restart option
		rly_category = CAT_LOW;
		rly_in = 4'b1011;
		cyc(8);
		chk(rly_contact, 4'b1011);
		chk(rly_fault_report_output, 4'b0000);
		rly_restart_en = 1'b1;
		rly_category = CAT_MID;
		rly_in = 4'b1111;
		cyc(40);
		chk(rly_contact, 4'b1111);
		chk(rly_fault_report_output, 4'b1111);
		rly_internal_ok = 4'b1110;
		cyc(10);
		chk(rly_fault_report_output, 4'b1110);
		// welded relay contactor: a feedback fault drops the report of that relay
		rly_internal_ok = 4'hf;
		stuck = 1'b1;
		rly_in = 4'b1110;
		cyc(21000);
		chk(rly_fault_report_output, 4'b1110);
		chk(rly_contact, 4'b1110);
		$display("test relay done");
		conclude();
	end
endmodule : sofm_top_test
